// File: tbc_pkg.sv
// Package for the two-wire bus control block: register map, field positions,
// reset values, condition timing and controller states.
// Assumes a 250 MHz system clock and a 32-bit AHB-Lite register bus.
package tbc_pkg;
   // Register byte addresses
   localparam logic [7:0] TBC_BUS_CONTROL_ADDR = 8'hC0;
   localparam logic [7:0] TBC_PIN_MODE_LOW_ADDR = 8'hC4;
   localparam logic [7:0] TBC_PIN_MODE_HIGH_ADDR = 8'hC8;
   localparam logic [7:0] TBC_IRQ_STATUS_ADDR = 8'hCC;
   localparam logic [7:0] TBC_IRQ_MASK_ADDR = 8'hD0;
   localparam logic [7:0] TBC_BUS_STATE_ADDR = 8'hD4;
   // Control field positions
   localparam int TBC_EN_BIT = 6;
   localparam int TBC_STA_BIT = 5;
   localparam int TBC_STO_BIT = 4;
   localparam int TBC_SI_BIT = 3;
   localparam int TBC_AA_BIT = 2;
   localparam logic [7:0] TBC_CONTROL_WMASK = 8'h7C;
   localparam logic [7:0] TBC_CONTROL_RESET = 8'h00;
   // Pin mode bits: bit0 SDA, bit1 SCL; open-drain is low=1, high=1
   localparam logic [1:0] TBC_PIN_MODE_RESET = 2'h0;
   localparam logic [1:0] TBC_PIN_MODE_OD = 2'h3;
   // Interrupt status bits
   localparam int TBC_IRQ_START_BIT = 0;
   localparam int TBC_IRQ_STOP_BIT = 1;
   localparam int TBC_IRQ_BYTE_BIT = 2;
   localparam logic [2:0] TBC_IRQ_RESET = 3'h0;
   // Condition half time in ns and in cycles (least time, rounded up)
   localparam int TBC_CLK_PERIOD_NS = 4;
   localparam int TBC_HALF_NS = 2500;
   localparam int TBC_HALF_CYCLES = (TBC_HALF_NS + TBC_CLK_PERIOD_NS - 1) / TBC_CLK_PERIOD_NS;
   localparam logic [2:0] TBC_BITS_PER_BYTE = 3'h7;

   typedef enum logic [2:0] {
      TBC_IDLE      = 3'b000,
      TBC_WAIT_FREE = 3'b001,
      TBC_START_A   = 3'b010,
      TBC_START_B   = 3'b011,
      TBC_OWN       = 3'b100,
      TBC_STOP_A    = 3'b101,
      TBC_STOP_B    = 3'b110,
      TBC_RSTART    = 3'b111
   } tbc_state_t;
endpackage : tbc_pkg

// File: tbc_bus_control.sv
// Two-wire bus control: enable, open-drain pin switch, START / repeated START /
// STOP requests, event hold of SCL, acknowledge drive, AHB-Lite register slave.
// Assumes open-drain SDA/SCL pins resolved outside and asynchronous to hclk.
//
// Behaviour
// - The bus interface is inactive while the enable bit is 0 and runs while it is 1.
// - Enabling the interface switches SDA and SCL to open-drain drive without software.
// - Enabling the interface makes both pin-mode select registers read back open-drain.
// - A start request on a free bus drives a START condition.
// - A start request on a busy bus waits for a STOP and then drives a START.
// - A start request while master after at least one byte drives a repeated START.
// - A write setting the start request is accepted at any time, also as slave.
// - The start request stays set after a START is seen; software clears it.
// - The control register sits at C0H, resets to zero, bits 7, 1 and 0 reserved.
// - A stop request as master sends STOP and self-clears once STOP is seen.
// - Start and stop requests together as master send STOP then START at once.
// - While the event flag is set SCL is held low and the transfer waits.
// - As receiver, SDA is driven low in the acknowledge pulse when ack assert is 1.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tbc_bus_control #(
   parameter int HALF_CYCLES = tbc_pkg::TBC_HALF_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        byte_done,
   input  wire logic        receiving,
   input  wire logic        ack_slot,
   output logic             irq
);

   typedef struct packed {
      logic [31:0]        hrdata;
      logic               hreadyout;
      logic               dph_wr;
      logic [7:0]         dph_addr;
      logic [7:0]         control;
      logic [1:0]         pin_mode_low;
      logic [1:0]         pin_mode_high;
      logic [2:0]         irq_status;
      logic [2:0]         irq_mask;
      logic               irq;
      logic [2:0]         sda_sync;
      logic [2:0]         scl_sync;
      logic               sda_seen;
      logic               scl_seen;
      logic               busy;
      logic               master;
      logic               bytes_done;
      tbc_pkg::tbc_state_t state;
      logic [15:0]        timer;
      logic               sda_drv_low;
      logic               scl_drv_low;
      logic               sda_out;
      logic               sda_oe;
      logic               scl_out;
      logic               scl_oe;
   } tbc_regs_t;

   tbc_regs_t r;
   tbc_regs_t next_r;

   logic [31:0] rd_mux;
   logic        start_seen;
   logic        stop_seen;
   logic        timer_done;
   logic        en;
   logic [7:0]  wdata8;

   // Register read mux; unmapped addresses read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         tbc_pkg::TBC_BUS_CONTROL_ADDR:   rd_mux = {24'h00_0000, r.control};
         tbc_pkg::TBC_PIN_MODE_LOW_ADDR:  rd_mux = {30'h0000_0000, r.pin_mode_low};
         tbc_pkg::TBC_PIN_MODE_HIGH_ADDR: rd_mux = {30'h0000_0000, r.pin_mode_high};
         tbc_pkg::TBC_IRQ_STATUS_ADDR:    rd_mux = {29'h0000_0000, r.irq_status};
         tbc_pkg::TBC_IRQ_MASK_ADDR:      rd_mux = {29'h0000_0000, r.irq_mask};
         tbc_pkg::TBC_BUS_STATE_ADDR:     rd_mux = {28'h000_0000, r.bytes_done, r.master, r.busy,
                                                    r.state != tbc_pkg::TBC_IDLE};
         default:                         rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus condition detection on agreed second and third sync stages
   assign start_seen = r.scl_seen && r.scl_sync[2] && r.sda_seen && !r.sda_sync[2] && !r.sda_sync[1];
   assign stop_seen  = r.scl_seen && r.scl_sync[2] && !r.sda_seen && r.sda_sync[2] && r.sda_sync[1];
   assign timer_done = (r.timer == 16'h0000);
   assign en         = r.control[tbc_pkg::TBC_EN_BIT];
   assign wdata8     = hwdata[7:0];

   // Next-state logic
   always_comb
   begin
      next_r = r;
      next_r.hreadyout = 1'b1;
      next_r.sda_sync = {r.sda_sync[1:0], sda_in};
      next_r.scl_sync = {r.scl_sync[1:0], scl_in};
      if (r.sda_sync[2] == r.sda_sync[1])
      begin
         next_r.sda_seen = r.sda_sync[2];
      end
      if (r.scl_sync[2] == r.scl_sync[1])
      begin
         next_r.scl_seen = r.scl_sync[2];
      end
      if (!timer_done)
      begin
         next_r.timer = r.timer - 16'h0001;
      end

      // Address phase capture
      next_r.dph_wr = hsel && hready && htrans[1] && hwrite;
      next_r.dph_addr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         next_r.hrdata = rd_mux;
      end

      // Bus busy tracking from observed conditions
      if (start_seen)
      begin
         next_r.busy = 1'b1;
      end
      if (stop_seen)
      begin
         next_r.busy = 1'b0;
         next_r.master = 1'b0;
         next_r.bytes_done = 1'b0;
      end
      if (byte_done && r.master)
      begin
         next_r.bytes_done = 1'b1;
      end

      // Data phase writes; start request accepted any time
      if (r.dph_wr)
      begin
         case (r.dph_addr)
            tbc_pkg::TBC_BUS_CONTROL_ADDR:
               next_r.control = wdata8 & tbc_pkg::TBC_CONTROL_WMASK;
            tbc_pkg::TBC_IRQ_STATUS_ADDR:
               next_r.irq_status = r.irq_status & ~hwdata[2:0];
            tbc_pkg::TBC_IRQ_MASK_ADDR:
               next_r.irq_mask = hwdata[2:0];
            default: ;
         endcase
      end

      // Events set sticky status, a byte event also sets the event flag; set wins over clear
      if (start_seen)
      begin
         next_r.irq_status[tbc_pkg::TBC_IRQ_START_BIT] = 1'b1;
      end
      if (stop_seen)
      begin
         next_r.irq_status[tbc_pkg::TBC_IRQ_STOP_BIT] = 1'b1;
      end
      if (byte_done && en)
      begin
         next_r.irq_status[tbc_pkg::TBC_IRQ_BYTE_BIT] = 1'b1;
         next_r.control[tbc_pkg::TBC_SI_BIT] = 1'b1;
      end
      // Stop request clears itself once a STOP is seen
      if (stop_seen && r.control[tbc_pkg::TBC_STO_BIT])
      begin
         next_r.control[tbc_pkg::TBC_STO_BIT] = 1'b0;
      end
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);

      // Pin mode registers follow the enable
      next_r.pin_mode_low  = en ? tbc_pkg::TBC_PIN_MODE_OD : tbc_pkg::TBC_PIN_MODE_RESET;
      next_r.pin_mode_high = en ? tbc_pkg::TBC_PIN_MODE_OD : tbc_pkg::TBC_PIN_MODE_RESET;

      // Condition sequencer
      if (!en)
      begin
         next_r.state = tbc_pkg::TBC_IDLE;
         next_r.sda_drv_low = 1'b0;
         next_r.scl_drv_low = 1'b0;
         next_r.master = 1'b0;
      end
      else
      begin
         case (r.state)
            tbc_pkg::TBC_IDLE, tbc_pkg::TBC_WAIT_FREE:
            begin
               // Slave receiver acknowledge while not master
               next_r.sda_drv_low = receiving && ack_slot && r.control[tbc_pkg::TBC_AA_BIT];
               if (r.state == tbc_pkg::TBC_IDLE && r.control[tbc_pkg::TBC_STA_BIT])
               begin
                  next_r.state = tbc_pkg::TBC_WAIT_FREE;
               end
               else if (r.state == tbc_pkg::TBC_WAIT_FREE && !r.busy && r.sda_seen && r.scl_seen)
               begin
                  next_r.sda_drv_low = 1'b0;
                  next_r.state = tbc_pkg::TBC_START_A;
                  next_r.timer = 16'(HALF_CYCLES);
               end
            end
            tbc_pkg::TBC_START_A:
               if (timer_done)
               begin
                  next_r.sda_drv_low = 1'b1;
                  next_r.timer = 16'(HALF_CYCLES);
                  next_r.state = tbc_pkg::TBC_START_B;
               end
            tbc_pkg::TBC_START_B:
               if (timer_done)
               begin
                  next_r.scl_drv_low = 1'b1;
                  next_r.master = 1'b1;
                  next_r.bytes_done = 1'b0;
                  next_r.state = tbc_pkg::TBC_OWN;
               end
            tbc_pkg::TBC_OWN:
               if (!r.control[tbc_pkg::TBC_SI_BIT])
               begin
                  if (r.control[tbc_pkg::TBC_STO_BIT])
                  begin
                     next_r.sda_drv_low = 1'b1;
                     next_r.timer = 16'(HALF_CYCLES);
                     next_r.state = tbc_pkg::TBC_STOP_A;
                  end
                  else if (r.control[tbc_pkg::TBC_STA_BIT] && r.bytes_done)
                  begin
                     next_r.sda_drv_low = 1'b0;
                     next_r.timer = 16'(HALF_CYCLES);
                     next_r.state = tbc_pkg::TBC_RSTART;
                  end
                  else
                  begin
                     next_r.sda_drv_low = receiving && ack_slot && r.control[tbc_pkg::TBC_AA_BIT];
                  end
               end
            tbc_pkg::TBC_RSTART:
               if (timer_done)
               begin
                  next_r.scl_drv_low = 1'b0;
                  next_r.timer = 16'(HALF_CYCLES);
                  next_r.state = tbc_pkg::TBC_START_A;
               end
            tbc_pkg::TBC_STOP_A:
               if (timer_done)
               begin
                  next_r.scl_drv_low = 1'b0;
                  next_r.timer = 16'(HALF_CYCLES);
                  next_r.state = tbc_pkg::TBC_STOP_B;
               end
            tbc_pkg::TBC_STOP_B:
               if (timer_done)
               begin
                  next_r.sda_drv_low = 1'b0;
                  next_r.master = 1'b0;
                  next_r.state = r.control[tbc_pkg::TBC_STA_BIT] ? tbc_pkg::TBC_WAIT_FREE
                                                                 : tbc_pkg::TBC_IDLE;
               end
            default:
               next_r.state = tbc_pkg::TBC_IDLE;
         endcase
      end

      // Open-drain drive: output low, enable only while pulling low
      next_r.sda_out = 1'b0;
      next_r.scl_out = 1'b0;
      next_r.sda_oe  = en && next_r.sda_drv_low;
      next_r.scl_oe  = en && (next_r.scl_drv_low || next_r.control[tbc_pkg::TBC_SI_BIT]);
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r <= '0;
         r.hreadyout <= 1'b1;
         r.control <= tbc_pkg::TBC_CONTROL_RESET;
         r.sda_sync <= 3'h7;
         r.scl_sync <= 3'h7;
         r.sda_seen <= 1'b1;
         r.scl_seen <= 1'b1;
         r.state <= tbc_pkg::TBC_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops, hresp tied low
   assign hrdata    = r.hrdata;
   assign hreadyout = r.hreadyout;
   assign hresp     = 1'b0;
   assign sda_out   = r.sda_out;
   assign sda_oe    = r.sda_oe;
   assign scl_out   = r.scl_out;
   assign scl_oe    = r.scl_oe;
   assign irq       = r.irq;

   // Disabled interface never drives a pin
   AST_DISABLED_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
      !$past(en) |-> !sda_oe && !scl_oe) else $error("pins driven while disabled");
   // Enable makes pin modes read open-drain one cycle later
   AST_PIN_MODE_OD: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(en) |=> r.pin_mode_low == tbc_pkg::TBC_PIN_MODE_OD && r.pin_mode_high == tbc_pkg::TBC_PIN_MODE_OD)
      else $error("pin mode not open-drain");
   // Start request is never cleared by hardware
   AST_STA_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
      r.control[tbc_pkg::TBC_STA_BIT] && !r.dph_wr |=> r.control[tbc_pkg::TBC_STA_BIT])
      else $error("start request cleared by hardware");
   // No START is driven while the bus is busy
   AST_WAIT_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
      r.state == tbc_pkg::TBC_WAIT_FREE && r.busy |=> r.state != tbc_pkg::TBC_START_A)
      else $error("start driven on busy bus");
   // Event flag holds SCL low unless software rewrites the control register
   AST_SI_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      en && r.control[tbc_pkg::TBC_SI_BIT] && !r.dph_wr |=> scl_oe)
      else $error("SCL not held during event");
   // Stop request clears after a seen STOP
   AST_STO_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_seen && r.control[tbc_pkg::TBC_STO_BIT] && !r.dph_wr |=> !r.control[tbc_pkg::TBC_STO_BIT])
      else $error("stop request not cleared");
   // Reserved bits read zero
   AST_RESERVED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      r.control[7] == 1'b0 && r.control[1:0] == 2'h0) else $error("reserved control bits set");
   // Start on free bus pulls SDA low right after the half time
   AST_START_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
      r.state == tbc_pkg::TBC_START_A && timer_done && en |=> sda_oe)
      else $error("START not driven");
   // Repeated START only once a byte has passed as master
   AST_RSTART_COND: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(r.state) && r.state == tbc_pkg::TBC_RSTART |-> $past(r.bytes_done))
      else $error("repeated START without byte");
   // Master receiver ack drive follows the ack-assert bit
   AST_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
      en && r.state == tbc_pkg::TBC_OWN && !r.control[tbc_pkg::TBC_SI_BIT] && !r.control[tbc_pkg::TBC_STO_BIT]
      && !r.control[tbc_pkg::TBC_STA_BIT] && receiving && ack_slot
      |=> sda_oe == $past(r.control[tbc_pkg::TBC_AA_BIT]))
      else $error("ack drive wrong");
   // Slave receiver ack drive follows the ack-assert bit
   AST_SLAVE_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
      en && r.state == tbc_pkg::TBC_IDLE && receiving && ack_slot |=> sda_oe == $past(r.control[tbc_pkg::TBC_AA_BIT]))
      else $error("slave ack drive wrong");

endmodule : tbc_bus_control
`default_nettype wire

// File: tbc_bus_partner.sv
// Far-side master on the two-wire bus, behavioural.
// Assumes the bench resolves open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tbc_bus_partner;
   logic sda_pull = 1'b0; // High pulls SDA low
   logic scl_pull = 1'b0; // High pulls SCL low
   // START: SDA falls while SCL is high, then clock goes low
   task start_cond;
      sda_pull = 1'b1;
      #62.5 scl_pull = 1'b1;
   endtask : start_cond
   // Eight clock pulses at 125 ns, data moves only while SCL is low
   task send_byte;
      for (int i = 0; i < 8; i++)
      begin
         sda_pull = i[0];
         #62.5 scl_pull = 1'b0;
         #62.5 scl_pull = 1'b1;
      end
   endtask : send_byte
   // STOP: SDA rises while SCL is high, then both lines stay free
   task stop_cond;
      sda_pull = 1'b1;
      #62.5 scl_pull = 1'b0;
      #62.5 sda_pull = 1'b0;
   endtask : stop_cond
endmodule : tbc_bus_partner
`default_nettype wire

// File: tb_tbc_bus_control.sv
// Self-checking bench for the two-wire bus control block.
// Assumes zero-wait AHB-Lite slave and a far-side partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_tbc_bus_control;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic sda_out, sda_oe, scl_out, scl_oe, irq;
   logic byte_done = 1'b0;
   logic receiving = 1'b0;
   logic ack_slot = 1'b0;
   logic sda_in, scl_in;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] rv;
   tbc_bus_partner peer_u();
   // Open-drain lines with pull-ups
   assign sda_in = !(sda_oe | peer_u.sda_pull);
   assign scl_in = !(scl_oe | peer_u.scl_pull);
   tbc_bus_control #(.HALF_CYCLES(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
      .scl_out(scl_out), .scl_oe(scl_oe), .byte_done(byte_done),
      .receiving(receiving), .ack_slot(ack_slot), .irq(irq));
   // Clock and hang limit
   always #2 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   // Verdict
   task summarize;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   // Compare seen against expected
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One AHB-Lite single word transfer
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : xfer
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask : rd_chk
   // Read until masked value matches, bounded
   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      int i;
      for (i = 0; i < 300; i++)
      begin
         xfer(1'b0, a, 32'h0);
         if ((rv & m) === exp)
            break;
      end
      chk(rv & m, exp);
   endtask : poll
   // Wait for an enable output to reach a level, bounded
   task wait_oe(input logic use_scl, input logic lvl);
      int i;
      for (i = 0; i < 2000; i++)
      begin
         @(negedge hclk);
         if ((use_scl ? scl_oe : sda_oe) === lvl)
            break;
      end
      chk({31'h0, use_scl ? scl_oe : sda_oe}, {31'h0, lvl});
   endtask : wait_oe
   // Main sequence
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(8'hC0, 32'h0);
      rd_chk(8'hC4, 32'h0);
      rd_chk(8'hC8, 32'h0);
      rd_chk(8'hE0, 32'h0);
      xfer(1'b1, 8'hC0, 32'h83);
      rd_chk(8'hC0, 32'h0);
      xfer(1'b1, 8'hC0, 32'h20);
      repeat (40) @(posedge hclk);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      rd_chk(8'hC0, 32'h20);
      // Line latches sit outside, pull-ups keep lines high
      xfer(1'b1, 8'hC0, 32'h40);
      rd_chk(8'hC4, 32'h3);
      rd_chk(8'hC8, 32'h3);
      repeat (40) @(posedge hclk);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      xfer(1'b1, 8'hC0, 32'h60);
      wait_oe(1'b0, 1'b1);
      chk(32'(scl_oe), 32'h0);
      chk(32'({hresp, sda_out, scl_out}), 32'h0);
      wait_oe(1'b1, 1'b1);
      rd_chk(8'hC0, 32'h60);
      poll(8'hCC, 32'h1, 32'h1);
      chk(32'(irq), 32'h0);
      xfer(1'b1, 8'hD0, 32'h1);
      rd_chk(8'hD0, 32'h1);
      chk(32'(irq), 32'h1);
      xfer(1'b1, 8'hCC, 32'h7);
      rd_chk(8'hCC, 32'h0);
      chk(32'(irq), 32'h0);
      xfer(1'b1, 8'hC0, 32'h40);
      @(posedge hclk) byte_done <= 1'b1;
      @(posedge hclk) byte_done <= 1'b0;
      repeat (60) @(posedge hclk);
      chk(32'(scl_oe), 32'h1);
      rd_chk(8'hC0, 32'h48);
      // A stop request must wait while the event flag stands
      xfer(1'b1, 8'hC0, 32'h58);
      repeat (30) @(posedge hclk);
      rd_chk(8'hC0, 32'h58);
      xfer(1'b1, 8'hCC, 32'h7);
      xfer(1'b1, 8'hC0, 32'h60);
      poll(8'hCC, 32'h1, 32'h1);
      xfer(1'b1, 8'hCC, 32'h7);
      xfer(1'b1, 8'hC0, 32'h70);
      poll(8'hCC, 32'h3, 32'h3);
      poll(8'hC0, 32'hFF, 32'h60);
      xfer(1'b1, 8'hC0, 32'h50);
      poll(8'hC0, 32'hFF, 32'h40);
      repeat (20) @(posedge hclk);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      xfer(1'b1, 8'hC0, 32'h44);
      @(posedge hclk);
      receiving <= 1'b1;
      ack_slot <= 1'b1;
      repeat (10) @(posedge hclk);
      chk(32'(sda_oe), 32'h1);
      xfer(1'b1, 8'hC0, 32'h40);
      repeat (10) @(posedge hclk);
      chk(32'(sda_oe), 32'h0);
      receiving <= 1'b0;
      ack_slot <= 1'b0;
      // Far side holds the bus; our start must wait for its STOP
      peer_u.start_cond();
      repeat (20) @(posedge hclk);
      xfer(1'b1, 8'hC0, 32'h60);
      peer_u.send_byte();
      chk(32'(sda_oe), 32'h0);
      peer_u.stop_cond();
      wait_oe(1'b0, 1'b1);
      chk(32'(scl_oe), 32'h0);
      xfer(1'b1, 8'hC0, 32'h00);
      repeat (20) @(posedge hclk);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      summarize();
   end
endmodule : tb_tbc_bus_control
`default_nettype wire
